/* src/tcc_cfg.svh */
// Register map, field positions, reset values and timing constants
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_STATUS 8'h04
`define TCC_OFF_IRQ_STAT 8'h08
`define TCC_OFF_IRQ_MASK 8'h0C
`define TCC_CTRL_RST 32'h00000001
`define TCC_IRQ_MASK_RST 32'h00000000
`define TCC_CTRL_EN_BIT 0
`define TCC_ST_ATTACHED_BIT 0
`define TCC_ST_ORIENT_BIT 1
`define TCC_ST_VCONN_BIT 2
`define TCC_ST_FAULT_BIT 3
`define TCC_ST_RESV_SEL_BIT 4
`define TCC_ST_BUS_FAULT_BIT 5
`define TCC_ST_LEVEL_LSB 8
`define TCC_EV_ATTACH_BIT 0
`define TCC_EV_DETACH_BIT 1
`define TCC_EV_FAULT_BIT 2
`define TCC_EV_BUS_FAULT_BIT 3
`define TCC_EV_WIDTH 4
`define TCC_PIN_COUNT 10
`define TCC_PIN_RST 10'h030
`define TCC_PIN_CC1_RD 0
`define TCC_PIN_CC2_RD 1
`define TCC_PIN_CC1_RA 2
`define TCC_PIN_CC2_RA 3
`define TCC_PIN_CABLE_POWER_FAULT_N_N 4
`define TCC_PIN_BUS_POWER_FAULT_N_N 5
`define TCC_PIN_SEL_A 6
`define TCC_PIN_SEL_B 7
`define TCC_PIN_VBUS_POL 8
`define TCC_PIN_VCONN_POL 9
`define TCC_STRAP_SETTLE 3'h4
`define TCC_CLK_MHZ 250
`define TCC_FAULT_MS 5
`endif

/* src/tcc_dfp_cc_controller.sv */
// Downstream-facing Type-C configuration-channel controller with APB registers
// Summary of operation
// - Unattached: stay idle and pull up both CC lines.
// - Sink pull-down seen on either CC line moves to attached.
// - Attach turns on the bus power enable output.
// - Line with pull-down sets orientation and lane mux select.
// - While attached, check the line in use stays in sink range.
// - While attached, pull up only the line in use.
// - While attached, advertise one of three current levels from selects.
// - Unused line in cable range gets cable power on its switch.
// - Cable power switches follow orientation, cable detection and fault.
// - Bus power fault causes no action, only reporting.
// - Cable fault longer than 5 ms latches cable power off until unplug.
// - Selects (sel_b, sel_a): 00 default, 10 mid, 11 high, 01 reserved.
// - Bus power polarity strap is sampled at reset and fixes polarity.
// - Attach indicator high while a sink is attached.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "tcc_cfg.svh"
module tcc_dfp_cc_controller #(
	parameter int FAULT_CYC = `TCC_FAULT_MS * `TCC_CLK_MHZ * 1000
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cc1_rd_det,
	input wire logic cc2_rd_det,
	input wire logic cc1_ra_det,
	input wire logic cc2_ra_det,
	input wire logic cable_power_fault_n,
	input wire logic bus_power_fault_n,
	input wire logic current_level_sel_a,
	input wire logic current_level_sel_b,
	input wire logic bus_power_polarity_strap,
	input wire logic cable_power_polarity_strap,
	output logic cc1_pullup_en,
	output logic cc2_pullup_en,
	output logic [1:0] current_level,
	output logic lane_mux_sel,
	output logic lane_mux_enable_n,
	output logic bus_power_enable,
	output logic cable_power_ctrl_a,
	output logic cable_power_ctrl_b,
	output logic attach_indicator,
	output logic irq
);
	logic [`TCC_PIN_COUNT-1:0] pin_raw;
	logic [`TCC_PIN_COUNT-1:0] pin_s1_reg;
	logic [`TCC_PIN_COUNT-1:0] pin_s2_reg;
	logic [`TCC_PIN_COUNT-1:0] pin_s3_reg;
	logic [`TCC_PIN_COUNT-1:0] pin_reg;
	logic [2:0] settle_reg;
	logic strap_done_reg;
	logic bus_pol_reg;
	logic cable_pol_reg;
	tcc_pkg::tcc_state_type state_reg;
	tcc_pkg::tcc_state_type state_next;
	logic orient_reg;
	logic [20:0] fault_cnt_reg;
	logic fault_latch_reg;
	logic vconn_on;
	logic rd_used;
	logic ra_unused;
	logic bus_fault_prev_reg;
	logic [31:0] ctrl_reg;
	logic [`TCC_EV_WIDTH-1:0] irq_stat_reg;
	logic [`TCC_EV_WIDTH-1:0] irq_mask_reg;
	logic [`TCC_EV_WIDTH-1:0] events;
	logic [`TCC_EV_WIDTH-1:0] w1c;
	logic [31:0] status;
	logic acc;
	logic wr_acc;
	logic hit;
	logic [1:0] level_reg;
	logic resv_sel;

	assign pin_raw = {cable_power_polarity_strap, bus_power_polarity_strap, current_level_sel_b,
		current_level_sel_a, bus_power_fault_n, cable_power_fault_n, cc2_ra_det, cc1_ra_det,
		cc2_rd_det, cc1_rd_det};

	// Pin filter: a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `TCC_PIN_COUNT; gi++)
		begin : g_pin
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					pin_s1_reg[gi] <= 1'(`TCC_PIN_RST >> gi);
					pin_s2_reg[gi] <= 1'(`TCC_PIN_RST >> gi);
					pin_s3_reg[gi] <= 1'(`TCC_PIN_RST >> gi);
					pin_reg[gi] <= 1'(`TCC_PIN_RST >> gi);
				end
				else
				begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
					if (pin_s2_reg[gi] == pin_s3_reg[gi])
						pin_reg[gi] <= pin_s3_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			settle_reg <= 3'h0;
			strap_done_reg <= 1'b0;
			bus_pol_reg <= 1'b1;
			cable_pol_reg <= 1'b1;
		end
		else if (!strap_done_reg)
		begin
			settle_reg <= settle_reg + 3'h1;
			if (settle_reg == `TCC_STRAP_SETTLE)
			begin
				strap_done_reg <= 1'b1;
				bus_pol_reg <= pin_reg[`TCC_PIN_VBUS_POL];
				cable_pol_reg <= pin_reg[`TCC_PIN_VCONN_POL];
			end
		end
	end

	assign rd_used = orient_reg ? pin_reg[`TCC_PIN_CC2_RD] : pin_reg[`TCC_PIN_CC1_RD];
	assign ra_unused = orient_reg ? pin_reg[`TCC_PIN_CC1_RA] : pin_reg[`TCC_PIN_CC2_RA];

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			tcc_pkg::TCC_UNATTACHED:
				if (strap_done_reg && ctrl_reg[`TCC_CTRL_EN_BIT] &&
					(pin_reg[`TCC_PIN_CC1_RD] || pin_reg[`TCC_PIN_CC2_RD]))
					state_next = tcc_pkg::TCC_ATTACHED;
			tcc_pkg::TCC_ATTACHED:
				if (!rd_used || !ctrl_reg[`TCC_CTRL_EN_BIT])
					state_next = tcc_pkg::TCC_UNATTACHED;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state_reg <= tcc_pkg::TCC_UNATTACHED;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			orient_reg <= 1'b0;
		else if (state_reg == tcc_pkg::TCC_UNATTACHED && state_next == tcc_pkg::TCC_ATTACHED)
			orient_reg <= !pin_reg[`TCC_PIN_CC1_RD];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || state_reg == tcc_pkg::TCC_UNATTACHED || pin_reg[`TCC_PIN_CABLE_POWER_FAULT_N_N])
			fault_cnt_reg <= 21'h0;
		else if (fault_cnt_reg <= 21'(FAULT_CYC))
			fault_cnt_reg <= fault_cnt_reg + 21'h1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || state_reg == tcc_pkg::TCC_UNATTACHED)
			fault_latch_reg <= 1'b0;
		else if (fault_cnt_reg > 21'(FAULT_CYC))
			fault_latch_reg <= 1'b1;
	end

	assign resv_sel = pin_reg[`TCC_PIN_SEL_A] && !pin_reg[`TCC_PIN_SEL_B];
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			level_reg <= tcc_pkg::TCC_LEVEL_DEFAULT;
		else if (!pin_reg[`TCC_PIN_SEL_B])
			level_reg <= tcc_pkg::TCC_LEVEL_DEFAULT;
		else if (pin_reg[`TCC_PIN_SEL_A])
			level_reg <= tcc_pkg::TCC_LEVEL_HIGH;
		else
			level_reg <= tcc_pkg::TCC_LEVEL_MID;
	end

	assign vconn_on = state_reg == tcc_pkg::TCC_ATTACHED && ra_unused && !fault_latch_reg;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cc1_pullup_en <= 1'b1;
			cc2_pullup_en <= 1'b1;
			current_level <= tcc_pkg::TCC_LEVEL_DEFAULT;
			lane_mux_sel <= 1'b0;
			lane_mux_enable_n <= 1'b1;
			bus_power_enable <= 1'b0;
			cable_power_ctrl_a <= 1'b0;
			cable_power_ctrl_b <= 1'b0;
			attach_indicator <= 1'b0;
		end
		else
		begin
			cc1_pullup_en <= state_reg == tcc_pkg::TCC_UNATTACHED || !orient_reg;
			cc2_pullup_en <= state_reg == tcc_pkg::TCC_UNATTACHED || orient_reg;
			current_level <= state_reg == tcc_pkg::TCC_ATTACHED ? level_reg :
				tcc_pkg::TCC_LEVEL_DEFAULT;
			lane_mux_sel <= orient_reg;
			lane_mux_enable_n <= state_reg != tcc_pkg::TCC_ATTACHED;
			bus_power_enable <= (state_reg == tcc_pkg::TCC_ATTACHED) ~^ bus_pol_reg;
			cable_power_ctrl_a <= (vconn_on && orient_reg) ~^ cable_pol_reg;
			cable_power_ctrl_b <= (vconn_on && !orient_reg) ~^ cable_pol_reg;
			attach_indicator <= state_reg == tcc_pkg::TCC_ATTACHED;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			bus_fault_prev_reg <= 1'b1;
		else
			bus_fault_prev_reg <= pin_reg[`TCC_PIN_BUS_POWER_FAULT_N_N];
	end

	assign events[`TCC_EV_ATTACH_BIT] = state_reg == tcc_pkg::TCC_UNATTACHED &&
		state_next == tcc_pkg::TCC_ATTACHED;
	assign events[`TCC_EV_DETACH_BIT] = state_reg == tcc_pkg::TCC_ATTACHED &&
		state_next == tcc_pkg::TCC_UNATTACHED;
	assign events[`TCC_EV_FAULT_BIT] = !fault_latch_reg && fault_cnt_reg > 21'(FAULT_CYC) &&
		state_reg == tcc_pkg::TCC_ATTACHED;
	assign events[`TCC_EV_BUS_FAULT_BIT] = bus_fault_prev_reg && !pin_reg[`TCC_PIN_BUS_POWER_FAULT_N_N];

	// APB slave: one wait state, write and read at the pready edge
	assign acc = psel && penable;
	assign wr_acc = acc && pready && pwrite;
	assign hit = paddr == `TCC_OFF_CTRL || paddr == `TCC_OFF_STATUS ||
		paddr == `TCC_OFF_IRQ_STAT || paddr == `TCC_OFF_IRQ_MASK;
	assign w1c = (wr_acc && paddr == `TCC_OFF_IRQ_STAT) ? pwdata[`TCC_EV_WIDTH-1:0] : '0;

	always_comb
	begin
		status = 32'h0;
		status[`TCC_ST_ATTACHED_BIT] = state_reg == tcc_pkg::TCC_ATTACHED;
		status[`TCC_ST_ORIENT_BIT] = orient_reg;
		status[`TCC_ST_VCONN_BIT] = vconn_on;
		status[`TCC_ST_FAULT_BIT] = fault_latch_reg;
		status[`TCC_ST_RESV_SEL_BIT] = resv_sel;
		status[`TCC_ST_BUS_FAULT_BIT] = !pin_reg[`TCC_PIN_BUS_POWER_FAULT_N_N];
		status[`TCC_ST_LEVEL_LSB +: 2] = level_reg;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= acc && !pready;
			pslverr <= acc && !pready && !hit;
			if (acc && !pready)
			begin
				unique case (paddr)
					`TCC_OFF_CTRL: prdata <= ctrl_reg;
					`TCC_OFF_STATUS: prdata <= status;
					`TCC_OFF_IRQ_STAT: prdata <= 32'(irq_stat_reg);
					`TCC_OFF_IRQ_MASK: prdata <= 32'(irq_mask_reg);
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_reg <= `TCC_CTRL_RST;
			irq_mask_reg <= `TCC_EV_WIDTH'(`TCC_IRQ_MASK_RST);
		end
		else if (wr_acc && paddr == `TCC_OFF_CTRL)
			ctrl_reg <= pwdata & `TCC_CTRL_RST;
		else if (wr_acc && paddr == `TCC_OFF_IRQ_MASK)
			irq_mask_reg <= pwdata[`TCC_EV_WIDTH-1:0];
	end

	// Sticky events: a new event wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_IDLE_PULLUPS: assert property ((state_reg == tcc_pkg::TCC_UNATTACHED) [*2] |->
		cc1_pullup_en && cc2_pullup_en) else $error("pull-ups missing while idle");
	AST_ATTACH_ENTRY: assert property (strap_done_reg && ctrl_reg[0] &&
		state_reg == tcc_pkg::TCC_UNATTACHED && (pin_reg[0] || pin_reg[1]) |=>
		state_reg == tcc_pkg::TCC_ATTACHED) else $error("attach missed");
	AST_BUS_POWER: assert property ($rose(state_reg == tcc_pkg::TCC_ATTACHED) |=>
		bus_power_enable == bus_pol_reg && attach_indicator) else $error("bus power late");
	AST_ORIENT_MUX: assert property ($rose(attach_indicator) |->
		lane_mux_sel == $past(!pin_reg[0], 2)) else $error("orientation wrong");
	AST_SINK_LOST: assert property (state_reg == tcc_pkg::TCC_ATTACHED && !rd_used |=>
		state_reg == tcc_pkg::TCC_UNATTACHED) else $error("detach missed");
	AST_ONE_PULLUP: assert property ((state_reg == tcc_pkg::TCC_ATTACHED) [*2] |->
		cc1_pullup_en != cc2_pullup_en && cc2_pullup_en == orient_reg)
		else $error("pull-up on unused line");
	AST_LEVEL: assert property (state_reg == tcc_pkg::TCC_ATTACHED |=>
		current_level == $past(level_reg) && current_level != 2'h3) else $error("level bad");
	AST_VCONN_UNUSED: assert property (vconn_on |=> (orient_reg ? cable_power_ctrl_a :
		cable_power_ctrl_b) == cable_pol_reg) else $error("cable power off");
	AST_CABLE_POWER_FAULT_N: assert property (fault_latch_reg |=> cable_power_ctrl_a != cable_pol_reg &&
		cable_power_ctrl_b != cable_pol_reg) else $error("cable power on in fault");
	AST_FAULT_TIME: assert property (fault_cnt_reg == 21'(FAULT_CYC) && !pin_reg[4] &&
		state_reg == tcc_pkg::TCC_ATTACHED ##1 !pin_reg[4] && state_reg == tcc_pkg::TCC_ATTACHED
		|=> fault_latch_reg) else $error("fault not latched");
	AST_FAULT_EARLY: assert property ($rose(fault_latch_reg) |-> $past(fault_cnt_reg) >
		21'(FAULT_CYC)) else $error("fault latched early");
	AST_DETACH_CLEAR: assert property ($fell(state_reg == tcc_pkg::TCC_ATTACHED) |=>
		!fault_latch_reg && !attach_indicator && bus_power_enable != bus_pol_reg)
		else $error("detach left outputs on");
	AST_MID_CODE: assert property (pin_reg[7:6] == 2'h2 |=> level_reg == tcc_pkg::TCC_LEVEL_MID)
		else $error("mid level decode");

	COV_ATTACH: cover property ($rose(attach_indicator));
	COV_FLIPPED: cover property ($rose(attach_indicator) && lane_mux_sel);
	COV_VCONN: cover property ($rose(vconn_on));
	COV_FAULT_LATCH: cover property ($rose(fault_latch_reg));
endmodule

/* src/tcc_pkg.sv */
// Types shared by the configuration-channel controller
package tcc_pkg;
	typedef enum logic {TCC_UNATTACHED, TCC_ATTACHED} tcc_state_type;
	typedef enum logic [1:0] {TCC_LEVEL_DEFAULT, TCC_LEVEL_MID, TCC_LEVEL_HIGH} tcc_level_type;
endpackage

/* verif/tcc_sink_model.sv */
// Sink and active cable model seen through the line comparators
`timescale 1ns/100ps
module tcc_sink_model (
	input wire logic [1:0] plug,
	input wire logic cable,
	input wire logic fault,
	input wire logic cc1_pullup_en,
	input wire logic cc2_pullup_en,
	output logic cc1_rd_det,
	output logic cc2_rd_det,
	output logic cc1_ra_det,
	output logic cc2_ra_det,
	output logic cable_power_fault_n
);
	// Sink pull-down only reads as such while the line is pulled up
	assign cc1_rd_det = plug == 2'h1 && cc1_pullup_en;
	assign cc2_rd_det = plug == 2'h2 && cc2_pullup_en;
	// Cable termination sits on the line the sink leaves unused
	assign cc1_ra_det = cable && plug == 2'h2;
	assign cc2_ra_det = cable && plug == 2'h1;
	assign cable_power_fault_n = !fault;
endmodule

/* verif/typec_dfp_cc_controller_test.sv */
// Self-checking bench for the configuration-channel controller
`timescale 1ns/100ps
module typec_dfp_cc_controller_test;
	localparam int FC = 50;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	logic cc1_rd, cc2_rd, cc1_ra, cc2_ra, vc_fault_n;
	logic bus_fault_n = 1'b1;
	logic sel_a = 1'b0;
	logic sel_b = 1'b0;
	logic bus_pol = 1'b1;
	logic cable_pol = 1'b1;
	logic [1:0] plug = 2'h0;
	logic cable = 1'b0;
	logic fault = 1'b0;
	logic cc1_pu, cc2_pu, mux_sel, mux_en_n, bus_en, ctrl_a, ctrl_b, att;
	logic [1:0] level;
	logic [9:0] outs;
	logic [31:0] q;
	logic e;
	int num_errors = 0;
	int tests_run = 0;

	always #2 clk = !clk;
	assign outs = {cc1_pu, cc2_pu, level, mux_sel, mux_en_n, bus_en, ctrl_a, ctrl_b, att};

	tcc_dfp_cc_controller #(.FAULT_CYC(FC)) DUT (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cc1_rd_det(cc1_rd), .cc2_rd_det(cc2_rd), .cc1_ra_det(cc1_ra), .cc2_ra_det(cc2_ra),
		.cable_power_fault_n(vc_fault_n), .bus_power_fault_n(bus_fault_n),
		.current_level_sel_a(sel_a), .current_level_sel_b(sel_b),
		.bus_power_polarity_strap(bus_pol), .cable_power_polarity_strap(cable_pol),
		.cc1_pullup_en(cc1_pu), .cc2_pullup_en(cc2_pu), .current_level(level),
		.lane_mux_sel(mux_sel), .lane_mux_enable_n(mux_en_n), .bus_power_enable(bus_en),
		.cable_power_ctrl_a(ctrl_a), .cable_power_ctrl_b(ctrl_b),
		.attach_indicator(att), .irq(irq));

	tcc_sink_model sink (.plug(plug), .cable(cable), .fault(fault),
		.cc1_pullup_en(cc1_pu), .cc2_pullup_en(cc2_pu), .cc1_rd_det(cc1_rd),
		.cc2_rd_det(cc2_rd), .cc1_ra_det(cc1_ra), .cc2_ra_det(cc2_ra),
		.cable_power_fault_n(vc_fault_n));

	function automatic logic [9:0] want(input logic [1:0] pu, lv, input logic ms, on, ca, cb);
		return {pu, lv, ms, !on, on ~^ bus_pol, ca ~^ cable_pol, cb ~^ cable_pol, on};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle(input logic v);
		int n;
		n = 0;
		while (att !== v && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic check_idle(input string what);
		check(what, 32'({outs[9:6], outs[4:0]}),
			32'({4'hC, 1'b1, !bus_pol, !cable_pol, !cable_pol, 1'b0}));
	endtask

	task automatic do_reset(input logic pol);
		@(posedge clk);
		bus_pol <= pol;
		cable_pol <= pol;
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (15) @(posedge clk);
		@(negedge clk);
		check_idle("reset outs");
	endtask

	task automatic t_regs();
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl reset", q, 32'h00000001);
		apb(1'b0, 8'h0C, 32'h0);
		check("mask reset", q, 32'h00000000);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		check("unmapped write err", 32'(e), 32'h00000001);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped read err", 32'(e), 32'h00000001);
		check("unmapped data", q, 32'h00000000);
	endtask

	// attach, orientation, level and cable power
	task automatic t_attach(input logic [1:0] p, input logic c, sa, sb, input logic [1:0] lv,
		input logic stay);
		@(posedge clk);
		plug <= p;
		cable <= c;
		sel_a <= sa;
		sel_b <= sb;
		settle(1'b1);
		check("attached outs", 32'(outs), 32'(want({p == 2'h1, p == 2'h2}, lv, p == 2'h2,
			1'b1, c && p == 2'h2, c && p == 2'h1)));
		apb(1'b0, 8'h04, 32'h0);
		check("status", {22'h0, q[9:8], 6'h0, q[1:0]}, {22'h0, lv, 6'h0, p == 2'h2, 1'b1});
		if (!stay)
		begin
			@(posedge clk);
			plug <= 2'h0;
			settle(1'b0);
			check_idle("detached outs");
		end
	endtask

	// Enable bit: clearing it forces detach and blocks attach
	task automatic t_ctrl();
		@(posedge clk);
		plug <= 2'h1;
		settle(1'b1);
		apb(1'b1, 8'h00, 32'h00000000);
		settle(1'b0);
		check_idle("disabled outs");
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl write", q, 32'h00000000);
		apb(1'b1, 8'h00, 32'hFFFFFFFF);
		apb(1'b0, 8'h00, 32'h0);
		check("ctrl readback", q, 32'h00000001);
		settle(1'b1);
		check("reenabled", 32'(att), 32'h00000001);
		@(posedge clk);
		plug <= 2'h0;
		settle(1'b0);
		check_idle("released outs");
	endtask

	task automatic t_fault();
		apb(1'b1, 8'h0C, 32'h00000004);
		t_attach(2'h1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1);
		bus_fault_n <= 1'b0;
		repeat (2)
		begin
			@(posedge clk);
			fault <= 1'b1;
			repeat (FC * 3 / 4) @(posedge clk);
			fault <= 1'b0;
			repeat (20) @(posedge clk);
		end
		@(negedge clk);
		check("short faults", 32'(outs), 32'(want(2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1)));
		apb(1'b0, 8'h04, 32'h0);
		check("bus fault status", 32'(q[5]), 32'h00000001);
		@(posedge clk);
		bus_fault_n <= 1'b1;
		fault <= 1'b1;
		repeat (2 * FC) @(posedge clk);
		fault <= 1'b0;
		repeat (20) @(negedge clk);
		check("latched off", 32'({irq, outs}), 32'({1'b1, want(2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0)}));
		apb(1'b0, 8'h08, 32'h0);
		check("fault event", 32'(q[2]), 32'h00000001);
		apb(1'b1, 8'h08, 32'h00000004);
		@(negedge clk);
		check("irq cleared", 32'(irq), 32'h00000000);
		@(posedge clk);
		plug <= 2'h0;
		settle(1'b0);
		t_attach(2'h1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
	endtask

	initial
	begin
		#100000;
		num_errors++;
		print_verdict();
	end

	initial
	begin
		do_reset(1'b1);
		t_regs();
		t_attach(2'h1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
		t_attach(2'h2, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0);
		t_attach(2'h1, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0);
		t_attach(2'h2, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0);
		t_ctrl();
		t_fault();
		do_reset(1'b0);
		t_attach(2'h1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
		print_verdict();
	end
endmodule
